// [fhd_params.svh]
// Constants of the panel video timing input: geometry, gap, timing limits.
// Assumes inclusion by fhd_pkg.sv, whose include also serves the design file; definitions only.
//
// Contract
// - Screen position comes only from rising edges of the valid strobe, never from syncs.
// - The pixel taken on the first clock edge after the strobe rises lands in the leftmost column.
// - A strobe rise after eight line periods of low starts a frame whose first line, begun by that rise, is the top row.
// - Lines shorter than 1920 pixels and frames shorter than 1080 lines are completed in black.
// - Each primary is an 8-bit unsigned intensity where a larger value is brighter.
// - The pixel word holds red, green and blue fields in that order, each MSB first.
// - The lane-map select input picks the first bit mapping when high, the second when low.
// - The rotation input high mirrors the picture left to right; low shows it normally.
// - Each serial lane carries seven bit slots per pixel clock period.
`ifndef FHD_PARAMS_SVH
`define FHD_PARAMS_SVH

`define FHD_H_ACTIVE_PIX   1920
`define FHD_H_ACTIVE_PAIRS 960
`define FHD_V_ACTIVE       1080
`define FHD_GAP_LINES      8
`define FHD_LANE_SLOTS     7
`define FHD_LANES          4
`define FHD_FIFO_DEPTH     16
`define FHD_SYS_CLK_HZ     40000000
`define FHD_BLACK          24'h000000

`endif

// [fhd_pkg.sv]
// Types shared by the panel video timing input.
// Assumes fhd_params.svh sits in the include path.
`include "fhd_params.svh"

package fhd_pkg;
  typedef logic [10:0] fhd_row_t;
  typedef logic [9:0]  fhd_col_t;
  typedef logic [23:0] fhd_rgb_t;

  typedef enum logic [1:0] {
    FHD_PAD_IDLE = 2'b01,
    FHD_PAD_RUN  = 2'b10
  } fhd_pad_e;

  // Lane word to {strobe, red, green, blue}; first selects mapping
  function automatic logic [24:0] fhd_decode(input logic [27:0] w, input logic first);
    logic [6:0] l0;
    logic [6:0] l1;
    logic [6:0] l2;
    logic [6:0] l3;
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
    l0 = w[6:0];
    l1 = w[13:7];
    l2 = w[20:14];
    l3 = w[27:21];
    if (first) begin
      r = {l3[1:0], l0[5:0]};
      g = {l3[3:2], l1[4:0], l0[6]};
      b = {l3[5:4], l2[3:0], l1[6:5]};
    end else begin
      r = {l0[5:0], l3[1:0]};
      g = {l1[4:0], l0[6], l3[3:2]};
      b = {l2[3:0], l1[6:5], l3[5:4]};
    end
    return {l2[6], r, g, b};
  endfunction : fhd_decode
endpackage : fhd_pkg

// [fhd_video_input.sv]
// Panel video timing input: samples the dual-channel lane words on the
// dot clock, places pixel pairs on the screen grid and pads in black.
// Assumes sys_clk at least four times the dot clock; pins are asynchronous.
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Pixel-pair FIFO
// ----------------------------------------------------------------
module fhd_fifo #(
  parameter int WIDTH = 69,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fhd_fifo: DEPTH must be a power of two");

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             mem_empty;
  logic             push;
  logic             pop;

  assign mem_empty = (wr_ptr == rd_ptr);
  assign in_ready  = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) || (wr_ptr[AW] == rd_ptr[AW]);
  assign push      = in_valid && in_ready;
  assign pop       = !mem_empty && (!out_valid || out_ready);

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // Registered output stage
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data  <= mem[rd_ptr[AW-1:0]];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule : fhd_fifo

// ----------------------------------------------------------------
// Top
// ----------------------------------------------------------------
module fhd_video_input
  import fhd_pkg::*;
#(
  parameter int FIFO_DEPTH = `FHD_FIFO_DEPTH
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        dot_rate_clock,
  input  wire logic [27:0] ch1_lanes,
  input  wire logic [27:0] ch2_lanes,
  input  wire logic        lane_map_first,
  input  wire logic        rotate,
  input  wire logic        pix_ready,
  output logic             pix_valid,
  output logic [10:0]      pix_row,
  output logic [9:0]       pix_pair,
  output logic [23:0]      pix_even,
  output logic [23:0]      pix_odd,
  output logic             frame_start,
  output logic             overflow
);
  localparam int WORD = 69;

  if (FIFO_DEPTH < 2) $error("fhd_video_input: FIFO_DEPTH too small");

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [58:0] pin_s1;
  logic [58:0] pin_s2;
  logic        clk_s3;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      clk_s3 <= 1'b0;
    end else begin
      pin_s1 <= {rotate, lane_map_first, dot_rate_clock, ch2_lanes, ch1_lanes};
      pin_s2 <= pin_s1;
      clk_s3 <= pin_s2[56];
    end
  end

  logic        dot_edge;
  logic [24:0] dec_even;
  logic [24:0] dec_odd;
  logic        strobe;

  assign dot_edge = pin_s2[56] && !clk_s3;
  assign dec_even = fhd_decode(pin_s2[27:0], pin_s2[57]);
  assign dec_odd  = fhd_decode(pin_s2[55:28], pin_s2[57]);
  assign strobe   = dec_even[24];

  // ----------------------------------------------------------------
  // Line and frame tracking on dot clock edges
  // ----------------------------------------------------------------
  logic        strobe_q;
  logic [10:0] line_len;
  logic [10:0] line_cnt;
  logic [15:0] low_cnt;
  logic [10:0] row;
  logic [9:0]  pair;
  logic        new_frame;
  logic        rise;
  logic        fall;

  function automatic logic [10:0] fhd_next_row(input logic [10:0] r, input logic frame);
    if (frame) return 11'h000;
    return (r == 11'h7ff) ? r : r + 1'b1;
  endfunction : fhd_next_row
  assign rise      = dot_edge && strobe && !strobe_q;
  assign fall      = dot_edge && !strobe && strobe_q;
  assign new_frame = rise && (low_cnt >= {2'b00, line_len, 3'b000});

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      strobe_q <= 1'b0;
      line_len <= 11'h7ff;
      line_cnt <= 11'h7ff;
      low_cnt  <= '0;
    end else if (dot_edge) begin
      strobe_q <= strobe;
      if (strobe && !strobe_q) begin
        line_len <= line_cnt;
        line_cnt <= 11'h001;
      end else if (line_cnt != 11'h7ff) begin
        line_cnt <= line_cnt + 1'b1;
      end
      if (strobe) low_cnt <= '0;
      else if (low_cnt != 16'hffff) low_cnt <= low_cnt + 1'b1;
    end
  end

  // Row and column come only from strobe rises
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      row  <= 11'h7ff;
      pair <= '0;
    end else if (rise) begin
      row  <= fhd_next_row(row, new_frame);
      pair <= 10'h001;
    end else if (dot_edge && strobe && pair != 10'h3ff) begin
      pair <= pair + 1'b1;
    end
  end

  // Live pair: first sample at the rise sits in pair 0
  logic        live;
  logic [10:0] live_row;
  logic [9:0]  live_pair;

  assign live      = dot_edge && strobe;
  assign live_row  = rise ? fhd_next_row(row, new_frame) : row;
  assign live_pair = rise ? 10'h000 : pair;

  // ----------------------------------------------------------------
  // Black padding engine
  // ----------------------------------------------------------------
  fhd_pad_e    pad_state;
  logic [10:0] pad_row;
  logic [10:0] pad_last;
  logic [9:0]  pad_pair;
  logic        fifo_ready;
  logic        pad_push;
  logic        short_frame;
  logic        short_line;

  assign short_line  = fall && pair < 10'(`FHD_H_ACTIVE_PAIRS) && row < 11'(`FHD_V_ACTIVE);
  assign short_frame = new_frame && row != 11'h7ff && row < 11'(`FHD_V_ACTIVE - 1);
  assign pad_push    = pad_state == FHD_PAD_RUN && !live && fifo_ready;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pad_state <= FHD_PAD_IDLE;
      pad_row   <= '0;
      pad_last  <= '0;
      pad_pair  <= '0;
    end else begin
      unique case (pad_state)
        FHD_PAD_IDLE: begin
          if (short_line) begin
            pad_state <= FHD_PAD_RUN;
            pad_row   <= row;
            pad_last  <= row;
            pad_pair  <= pair;
          end else if (short_frame) begin
            pad_state <= FHD_PAD_RUN;
            pad_row   <= row + 1'b1;
            pad_last  <= 11'(`FHD_V_ACTIVE - 1);
            pad_pair  <= '0;
          end
        end
        FHD_PAD_RUN: begin
          if (pad_push) begin
            if (pad_pair == 10'(`FHD_H_ACTIVE_PAIRS - 1)) begin
              pad_pair <= '0;
              pad_row  <= pad_row + 1'b1;
              if (pad_row == pad_last) pad_state <= FHD_PAD_IDLE;
            end else begin
              pad_pair <= pad_pair + 1'b1;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Write side: mirror, colour fields, overflow
  // ----------------------------------------------------------------
  logic             wr_valid;
  logic [WORD-1:0]  wr_word;
  logic [9:0]       put_pair;
  fhd_rgb_t         put_even;
  fhd_rgb_t         put_odd;
  logic             live_in;

  assign live_in = live && live_pair < 10'(`FHD_H_ACTIVE_PAIRS) && live_row < 11'(`FHD_V_ACTIVE);

  always_comb begin
    put_pair = live ? live_pair : pad_pair;
    put_even = live ? dec_even[23:0] : `FHD_BLACK;
    put_odd  = live ? dec_odd[23:0] : `FHD_BLACK;
    if (pin_s2[58]) begin
      wr_word = {(live ? live_row : pad_row), 10'(`FHD_H_ACTIVE_PAIRS - 1) - put_pair,
                 put_odd, put_even};
    end else begin
      wr_word = {(live ? live_row : pad_row), put_pair, put_even, put_odd};
    end
  end

  assign wr_valid = live_in || pad_push;

  always_ff @(posedge sys_clk) begin
    if (rst) overflow <= 1'b0;
    else if (live_in && !fifo_ready) overflow <= 1'b1;
  end

  // ----------------------------------------------------------------
  // FIFO and output registers
  // ----------------------------------------------------------------
  logic            rd_valid;
  logic [WORD-1:0] rd_word;

  fhd_fifo #(.WIDTH(WORD), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .in_valid (wr_valid),
    .in_ready (fifo_ready),
    .in_data  (wr_word),
    .out_valid(rd_valid),
    .out_ready(!pix_valid || pix_ready),
    .out_data (rd_word)
  );

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pix_valid   <= 1'b0;
      pix_row     <= '0;
      pix_pair    <= '0;
      pix_even    <= '0;
      pix_odd     <= '0;
      frame_start <= 1'b0;
    end else if (!pix_valid || pix_ready) begin
      pix_valid   <= rd_valid;
      pix_row     <= rd_word[68:58];
      pix_pair    <= rd_word[57:48];
      pix_even    <= rd_word[47:24];
      pix_odd     <= rd_word[23:0];
      frame_start <= rd_valid && rd_word[68:58] == 11'h000 && rd_word[57:48] == 10'h000;
    end
  end
endmodule : fhd_video_input

// [fhd_properties.sv]
// Assertions on the ports of the video timing input top.
// Assumes binding into fhd_video_input; one clock domain, rst synchronous.
`timescale 1ns/1ps
module fhd_vi_chk #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        dot_rate_clock,
  input wire logic [27:0] ch1_lanes,
  input wire logic [27:0] ch2_lanes,
  input wire logic        lane_map_first,
  input wire logic        rotate,
  input wire logic        pix_ready,
  input wire logic        pix_valid,
  input wire logic [10:0] pix_row,
  input wire logic [9:0]  pix_pair,
  input wire logic [23:0] pix_even,
  input wire logic [23:0] pix_odd,
  input wire logic        frame_start,
  input wire logic        overflow
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_hold;
    pix_valid && !pix_ready |=> pix_valid && $stable({pix_row, pix_pair, pix_even, pix_odd});
  endproperty
  a_hold: assert property (p_hold) else $error("held word changed");
  property p_range;
    pix_valid |-> pix_row < 11'h438 && pix_pair < 10'h3c0;
  endproperty
  a_range: assert property (p_range) else $error("word off screen");
  property p_fs_pos;
    frame_start |-> pix_valid && pix_row == 11'h0 && pix_pair == 10'h0;
  endproperty
  a_fs_pos: assert property (p_fs_pos) else $error("frame start misplaced");
  property p_fs_once;
    frame_start && pix_ready |=> !frame_start;
  endproperty
  a_fs_once: assert property (p_fs_once) else $error("frame start repeated");
  property p_top_left;
    pix_valid && pix_row == 11'h0 && pix_pair == 10'h0 && !rotate |-> frame_start;
  endproperty
  a_top_left: assert property (p_top_left) else $error("top left without frame start");
  property p_ovf_keep;
    overflow |=> overflow;
  endproperty
  a_ovf_keep: assert property (p_ovf_keep) else $error("overflow cleared");
  property p_ovf_cause;
    $rose(overflow) |-> $past(pix_valid && !pix_ready);
  endproperty
  a_ovf_cause: assert property (p_ovf_cause) else $error("overflow without stall");
  property p_rst;
    disable iff (1'b0) rst |=> !pix_valid && !overflow && !frame_start;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs live in reset");
endmodule : fhd_vi_chk

bind fhd_video_input fhd_vi_chk #(.FIFO_DEPTH(FIFO_DEPTH)) fhd_vi_chk_inst (
  .sys_clk(sys_clk), .rst(rst), .dot_rate_clock(dot_rate_clock), .ch1_lanes(ch1_lanes),
  .ch2_lanes(ch2_lanes), .lane_map_first(lane_map_first), .rotate(rotate),
  .pix_ready(pix_ready), .pix_valid(pix_valid), .pix_row(pix_row), .pix_pair(pix_pair),
  .pix_even(pix_even), .pix_odd(pix_odd), .frame_start(frame_start), .overflow(overflow)
);

// [fhd_src_model.sv]
// Video source model: free-running dot clock and two lane channels.
// Assumes the bench calls its tasks; map_first follows the panel select.
`timescale 1ns/1ps
module fhd_src_model (
  input  wire logic   map_first,
  output logic        dot_rate_clock,
  output logic [27:0] ch1_lanes,
  output logic [27:0] ch2_lanes
);
  initial begin
    dot_rate_clock = 1'b0;
    ch1_lanes = 28'h0;
    ch2_lanes = 28'h0;
    forever #100 dot_rate_clock = ~dot_rate_clock;
  end
  // Row 0 walks the eight basic colours
  function automatic logic [23:0] pix_col(input int r, input int x);
    if (r == 0) return {{8{x[0]}}, {8{x[1]}}, {8{x[2]}}};
    return {8'(x * 37), 8'(r) ^ 8'h5a, 8'(255 - x)};
  endfunction : pix_col
  function automatic logic [27:0] enc(input logic [23:0] c, input logic de);
    logic [1:0] rh, gh, bh;
    logic [5:0] r6, g6, b6;
    {rh, r6} = map_first ? {c[23:22], c[21:16]} : {c[17:16], c[23:18]};
    {gh, g6} = map_first ? {c[15:14], c[13:8]} : {c[9:8], c[15:10]};
    {bh, b6} = map_first ? {c[7:6], c[5:0]} : {c[1:0], c[7:2]};
    return {1'b0, bh, gh, rh, de, 2'b00, b6, g6, r6};
  endfunction : enc
  task automatic idle(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge dot_rate_clock);
      ch1_lanes <= ~ch1_lanes & ~28'h100000;
      ch2_lanes <= ~ch2_lanes & ~28'h100000;
    end
  endtask : idle
  task automatic send_line(input int row, input int np, input int nb);
    for (int i = 0; i < np; i++) begin
      @(negedge dot_rate_clock);
      ch1_lanes <= enc(pix_col(row, 2 * i), 1'b1);
      ch2_lanes <= enc(pix_col(row, 2 * i + 1), 1'b1);
    end
    idle(nb);
  endtask : send_line
endmodule : fhd_src_model

// [fhd_video_input_tb.sv]
// Self-checking bench for the video timing input.
// Assumes the source model drives the link; sys_clk 40 MHz.
`timescale 1ns/1ps
module fhd_video_input_tb;
  localparam int NP = 4;
  localparam int LP = 160;
  logic        sys_clk, rst, lane_map_first, rotate, pix_ready, dot_rate_clock;
  logic        pix_valid, frame_start, overflow, mon_on;
  logic [27:0] ch1_lanes, ch2_lanes;
  logic [10:0] pix_row;
  logic [9:0]  pix_pair;
  logic [23:0] pix_even, pix_odd;
  logic [3:0]  rot_row;
  int          n_errors, n_checks, n_words, mr, mp, sw;
  fhd_src_model fhd_src_model_inst (.map_first(lane_map_first),
    .dot_rate_clock(dot_rate_clock), .ch1_lanes(ch1_lanes), .ch2_lanes(ch2_lanes));
  fhd_video_input #(.FIFO_DEPTH(16)) fhd_video_input_inst (.sys_clk(sys_clk), .rst(rst),
    .dot_rate_clock(dot_rate_clock), .ch1_lanes(ch1_lanes), .ch2_lanes(ch2_lanes),
    .lane_map_first(lane_map_first), .rotate(rotate), .pix_ready(pix_ready),
    .pix_valid(pix_valid), .pix_row(pix_row), .pix_pair(pix_pair), .pix_even(pix_even),
    .pix_odd(pix_odd), .frame_start(frame_start), .overflow(overflow));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  function automatic logic [23:0] ex(input int r, input int x);
    return (x < 2 * NP) ? fhd_src_model_inst.pix_col(r, x) : 24'h000000;
  endfunction : ex
  task automatic send(input int r, input int np, input int nb);
    fhd_src_model_inst.send_line(r, np, nb);
  endtask : send
  // Every accepted word against its place on the grid
  always @(posedge sys_clk) begin
    if (mon_on && pix_valid === 1'b1 && pix_ready) begin
      mr = int'(pix_row);
      sw = int'(rot_row[mr[1:0]]);
      mp = sw ? 959 - int'(pix_pair) : int'(pix_pair);
      n_words++;
      chk(24'(pix_row < 11'h3), 24'h1);
      chk(pix_even, ex(mr, 2 * mp + sw));
      chk(pix_odd, ex(mr, 2 * mp + 1 - sw));
      chk(24'(frame_start), 24'(mr == 0 && mp == 0));
    end
  end
  task automatic t_frame;
    send(7, NP, LP - NP);
    send(7, NP, LP - NP);
    fhd_src_model_inst.idle(8 * LP);
    send(0, NP, LP - NP);
  endtask : t_frame
  task automatic t_map;
    @(negedge sys_clk);
    lane_map_first = 1'b0;
    fhd_src_model_inst.idle(1);
    send(1, NP, LP - NP);
  endtask : t_map
  task automatic t_mirror;
    @(negedge sys_clk);
    lane_map_first = 1'b1;
    rotate = 1'b1;
    rot_row[2] = 1'b1;
    fhd_src_model_inst.idle(1);
    send(2, NP, LP - NP);
    chk(24'(n_words), 24'(3 * 960));
  endtask : t_mirror
  task automatic t_overflow;
    @(negedge sys_clk);
    mon_on = 1'b0;
    pix_ready = 1'b0;
    send(3, 24, 8);
    chk(24'({overflow, pix_valid}), 24'h3);
    chk(24'({pix_row, pix_pair}), 24'({11'h3, 10'h3bf}));
    chk(pix_even, ex(3, 1));
    chk(pix_odd, ex(3, 0));
  endtask : t_overflow
  task automatic t_reset;
    @(negedge sys_clk);
    rst = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk(24'({pix_valid, frame_start, overflow}), 24'h0);
    rst = 1'b0;
  endtask : t_reset
  initial begin
    {n_errors, n_checks, n_words} = '0;
    rst = 1'b1;
    lane_map_first = 1'b1;
    rotate = 1'b0;
    pix_ready = 1'b1;
    mon_on = 1'b1;
    rot_row = 4'h0;
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    t_frame();
    t_map();
    t_mirror();
    t_overflow();
    t_reset();
    report_and_stop();
  end
  initial begin
    #1000000;
    n_errors++;
    report_and_stop();
  end
endmodule : fhd_video_input_tb
